// ===== design/halt_wake_reset_control.sv
// Purpose: halt entry, wake decision, reset cause flags and register reset images
// Assumes: osc_tick_in is a one-cycle pulse per 32768Hz oscillator tick, same clock
// Notes:   srst_in models power-up; the core consumes the enables and strobes below
`timescale 1ns/1ns
module halt_wake_reset_control
  import halt_wake_pkg::*;
(
  input  wire logic                 clock_in,
  input  wire logic                 srst_in,
  input  wire logic                 osc_tick_in,
  input  wire logic                 halt_instr_in,
  input  wire logic                 clear_wdt_instr_in,
  input  wire logic                 external_reset_pin_n_in,
  input  wire logic                 low_voltage_reset_enable_in,
  input  wire logic                 supply_low_in,
  input  wire logic [7:0]           port_a_pins_in,
  input  wire logic [7:0]           port_a_wake_enable_in,
  input  wire logic                 lcd_run_in_halt_in,
  input  wire logic [INT_SRC_N-1:0] int_request_in,
  input  wire logic [INT_SRC_N-1:0] int_enable_in,
  input  wire logic                 global_int_enable_in,
  input  wire logic                 stack_full_in,
  output logic                      system_clock_enable_out,
  output logic                      quarter_rate_clock_out,
  output logic                      timebase_rtc_run_out,
  output logic                      lcd_run_out,
  output logic                      hold_state_out,
  output logic                      chip_reset_out,
  output logic                      warm_reset_out,
  output logic                      resume_next_out,
  output logic                      isr_start_out,
  output logic                      timeout_flag_out,
  output logic                      power_down_flag_out,
  output logic [WDT_W-1:0]          wdt_count_out,
  output logic [7:0]                timer_ctrl_out,
  output logic [5:0]                rtc_control_reg_out,
  output logic [7:0]                port_a_latch_out,
  output logic [7:0]                interrupt_control_low_out,
  output logic                      ports_input_mode_out
);

  typedef struct packed {
    state_type                 state;
    logic [STARTUP_CNT_W-1:0]  startup_cnt;
    logic [WDT_W-1:0]          wdt;
    logic [1:0]                quarter_div;
    logic                      quarter_clk;
    logic                      sys_en;
    logic                      tb_run;
    logic                      lcd_run;
    logic                      hold;
    logic                      chip_reset;
    logic                      warm_reset;
    logic                      resume_next;
    logic                      isr_start;
    logic                      isr_wait;
    logic                      timeout_flag;
    logic                      power_down_flag;
    logic [INT_SRC_N-1:0]      int_armed;
    logic [7:0]                port_prev;
    logic [7:0]                timer_ctrl;
    logic [5:0]                rtc_ctrl;
    logic [7:0]                port_a;
    logic [7:0]                int_ctrl;
    logic                      ports_input;
  } regs_type;

  localparam regs_type REGS_RESET = '{
    state:           ST_STARTUP,
    startup_cnt:     '0,
    wdt:             '0,
    quarter_div:     2'h0,
    quarter_clk:     1'b0,
    sys_en:          1'b0,
    tb_run:          1'b0,
    lcd_run:         1'b0,
    hold:            1'b0,
    chip_reset:      1'b1,
    warm_reset:      1'b0,
    resume_next:     1'b0,
    isr_start:       1'b0,
    isr_wait:        1'b0,
    timeout_flag:    1'b0,
    power_down_flag: 1'b0,
    int_armed:       '0,
    port_prev:       PORT_A_RESET,
    timer_ctrl:      TIMER_CTRL_RESET,
    rtc_ctrl:        RTC_CTRL_RESET,
    port_a:          PORT_A_RESET,
    int_ctrl:        INT_CTRL_RESET,
    ports_input:     1'b1
  };

  regs_type r;
  regs_type next_r;

  logic       reset_pin_n_sync;
  logic [7:0] port_a_sync;

  // pin inputs cross into the clock domain before any decision uses them
  pin_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_reset_sync (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .async_in (external_reset_pin_n_in),
    .sync_out (reset_pin_n_sync)          // RL20
  );

  pin_sync #(.WIDTH(8), .RESET_VALUE(PORT_A_RESET)) u_port_sync (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .async_in (port_a_pins_in),
    .sync_out (port_a_sync)
  );

  // full chip reset image shared by pin, low voltage and normal watchdog resets
  function automatic regs_type apply_chip_reset(input regs_type cur);
    regs_type v;
    v             = cur;
    v.state       = ST_RESET;
    v.chip_reset  = 1'b1;
    v.sys_en      = 1'b0;
    v.hold        = 1'b0;
    v.wdt         = '0;                   // RL16
    v.quarter_div = 2'h0;                 // RL16
    v.quarter_clk = 1'b0;
    v.int_ctrl    = INT_CTRL_RESET;       // RL16
    v.ports_input = 1'b1;                 // RL16
    v.timer_ctrl  = TIMER_CTRL_RESET;     // RL17
    v.rtc_ctrl    = RTC_CTRL_RESET;       // RL17
    v.port_a      = PORT_A_RESET;         // RL17
    v.isr_wait    = 1'b0;
    return v;
  endfunction : apply_chip_reset

  logic                 wdt_overflow;
  logic                 lv_reset;
  logic                 pin_reset;
  logic [7:0]           port_fall;
  logic [INT_SRC_N-1:0] int_wake;
  logic                 int_vector;

  always_comb begin
    next_r       = r;
    pin_reset    = ~reset_pin_n_sync;
    lv_reset     = low_voltage_reset_enable_in & supply_low_in;
    wdt_overflow = osc_tick_in && (r.wdt == {WDT_W{1'b1}});
    port_fall    = r.port_prev & ~port_a_sync & port_a_wake_enable_in;        // RL9
    int_wake     = int_request_in & r.int_armed;                              // RL11
    int_vector   = global_int_enable_in && |(int_wake & int_enable_in) && !stack_full_in; // RL10

    // one-cycle strobes default low
    next_r.warm_reset  = 1'b0;
    next_r.resume_next = 1'b0;
    next_r.isr_start   = 1'b0;
    next_r.port_prev   = port_a_sync;

    // watchdog counts oscillator ticks in every state but startup and reset
    if (osc_tick_in) begin
      next_r.wdt = r.wdt + 1'b1;
    end
    if (clear_wdt_instr_in && r.state == ST_RUN) begin
      next_r.wdt             = '0;
      next_r.power_down_flag = 1'b0;      // RL8
    end

    // quarter rate clock toggles on every second system clock slot
    if (r.sys_en) begin
      next_r.quarter_div = r.quarter_div + 1'b1;
      if (r.quarter_div[0]) begin
        next_r.quarter_clk = ~r.quarter_clk;
      end
    end

    case (r.state)
      ST_STARTUP: begin
        // oscillator settling window before the first fetch
        if (osc_tick_in) begin
          next_r.startup_cnt = r.startup_cnt + 1'b1;
        end
        next_r.wdt = '0;
        if (osc_tick_in && r.startup_cnt == STARTUP_CNT_W'(STARTUP_PULSES - 1)) begin // RL15
          next_r.state      = ST_RUN;
          next_r.chip_reset = 1'b0;
          next_r.sys_en     = 1'b1;
          next_r.tb_run     = 1'b1;
        end
      end
      ST_RUN: begin
        next_r.tb_run  = 1'b1;
        next_r.lcd_run = 1'b1;
        if (pin_reset || lv_reset) begin
          next_r = apply_chip_reset(next_r);                                 // RL13
        end else if (wdt_overflow) begin
          next_r              = apply_chip_reset(next_r);                    // RL18
          next_r.timeout_flag = 1'b1;                                        // RL14
        end else if (halt_instr_in) begin
          next_r.state           = ST_HALT;
          next_r.sys_en          = 1'b0;                                     // RL1
          next_r.hold            = 1'b1;                                     // RL2
          next_r.wdt             = '0;                                       // RL3
          next_r.power_down_flag = 1'b1;                                     // RL4
          next_r.timeout_flag    = 1'b0;                                     // RL4
          next_r.int_armed       = ~int_request_in;                          // RL11
          next_r.lcd_run         = lcd_run_in_halt_in;                       // RL5
        end
      end
      ST_HALT: begin
        next_r.tb_run = 1'b1;                                                // RL5
        // reset causes outrank the watchdog, which outranks the soft wakes
        if (pin_reset || lv_reset) begin
          next_r                 = apply_chip_reset(next_r);                 // RL6
          next_r.timeout_flag    = 1'b0;                                     // RL14
          next_r.power_down_flag = 1'b1;                                     // RL14
        end else if (wdt_overflow) begin
          next_r.state        = ST_RUN;                                      // RL6
          next_r.warm_reset   = 1'b1;                                        // RL7
          next_r.timeout_flag = 1'b1;                                        // RL7
          next_r.wdt          = '0;
          next_r.sys_en       = 1'b1;
          next_r.hold         = 1'b0;
          next_r.lcd_run      = 1'b1;
        end else if (|port_fall || |int_wake) begin
          next_r.hold    = 1'b0;                                             // RL6
          next_r.sys_en  = 1'b1;
          next_r.lcd_run = 1'b1;
          if (!(|port_fall) && int_vector) begin
            next_r.state    = ST_ISR_WAIT;                                   // RL12
            next_r.isr_wait = 1'b1;
          end else begin
            next_r.state       = ST_RUN;
            next_r.resume_next = 1'b1;                                       // RL12
          end
        end
      end
      ST_ISR_WAIT: begin
        // one extra dummy cycle so the service routine starts two cycles after wake
        next_r.isr_wait = 1'b0;
        if (!r.isr_wait) begin
          next_r.state     = ST_RUN;
          next_r.isr_start = 1'b1;                                           // RL12
        end
      end
      ST_RESET: begin
        next_r.wdt = '0;
        // held while any reset source stays active, then counting restarts
        if (!(pin_reset || lv_reset)) begin
          next_r.state      = ST_RUN;                                        // RL16
          next_r.chip_reset = 1'b0;
          next_r.sys_en     = 1'b1;
          next_r.tb_run     = 1'b1;
        end
      end
      default: begin
        next_r = REGS_RESET;
      end
    endcase
  end

  // power-up and the default state branch are the only places both flags are forced clear
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      r <= REGS_RESET;                    // RL14
    end else begin
      r <= next_r;
    end
  end

  // every output straight from the state register
  assign system_clock_enable_out   = r.sys_en;
  assign quarter_rate_clock_out    = r.quarter_clk;
  assign timebase_rtc_run_out      = r.tb_run;
  assign lcd_run_out               = r.lcd_run;
  assign hold_state_out            = r.hold;
  assign chip_reset_out            = r.chip_reset;
  assign warm_reset_out            = r.warm_reset;
  assign resume_next_out           = r.resume_next;
  assign isr_start_out             = r.isr_start;
  assign timeout_flag_out          = r.timeout_flag;    // RL19
  assign power_down_flag_out       = r.power_down_flag; // RL19
  assign wdt_count_out             = r.wdt;
  assign timer_ctrl_out            = r.timer_ctrl;
  assign rtc_control_reg_out       = r.rtc_ctrl;
  assign port_a_latch_out          = r.port_a;
  assign interrupt_control_low_out = r.int_ctrl;
  assign ports_input_mode_out      = r.ports_input;

endmodule : halt_wake_reset_control

// ===== design/pin_sync.sv
// Purpose: two flip-flop synchroniser for a vector of pin inputs
// Assumes: single clock domain, synchronous reset
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // two stages against metastability
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      stage1   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync

// ===== inc/halt_wake_pkg.sv
// Purpose: constants and types shared by the halt, wake and reset controller
// Assumes: 125 MHz clock_in stands in for the oscillator clock domain
// Notes:   register reset images are bit patterns of the control registers
// How it works
// RL1: halt instruction gates off system clock and quarter rate clock, oscillator keeps running
// RL2: while halted, ram, registers and port states are held unchanged
// RL3: entering halt clears the watchdog counter, which restarts from zero
// RL4: halt sets power down flag and clears timeout flag
// RL5: time base and rtc run in halt; lcd runs when option set
// RL6: wake on external reset, interrupt, enabled port a falling edge, watchdog overflow
// RL7: watchdog overflow in halt resets only pc and sp, sets timeout flag
// RL8: power down flag cleared at power up and watchdog clear, set by halt
// RL9: each port a bit has its own wake enable; pin wake resumes next instruction
// RL10: interrupt wake resumes next instruction if disabled or stack full, else vectors
// RL11: interrupt flag already set at halt entry cannot wake the device
// RL12: interrupt response starts more than one cycle later; resume is immediate
// RL13: chip reset from pin, watchdog in normal run, or enabled low voltage reset
// RL14: timeout and power down flags record reset cause per cause table
// RL15: power up holds reset an extra 8192 system clock pulses; code counts 8192 osc_tick_in pulses instead
// RL16: chip reset zeroes pc, disables interrupts, clears dividers, timer off, ports input
// RL17: pin or normal watchdog reset loads timer, rtc, port a images; warm keeps
// RL18: watchdog overflow in normal run gives full chip reset and sets timeout
// RL19: timeout and power down flags are readable outputs
// RL20: external reset pin is synchronised before use
package halt_wake_pkg;
  localparam int unsigned STARTUP_PULSES    = 8192;
  localparam int unsigned STARTUP_CNT_W     = 14;
  localparam int unsigned WDT_W             = 16;   // overflow at 2^16 osc ticks
  localparam int unsigned INT_SRC_N         = 4;
  localparam int unsigned ISR_DELAY_CYCLES  = 2;    // more than one cycle
  localparam logic [7:0]  TIMER_CTRL_RESET  = 8'h08; // upper bits 0000 1, rest 0
  localparam logic [5:0]  RTC_CTRL_RESET    = 6'h07; // xx 0111, x taken as 0
  localparam logic [7:0]  PORT_A_RESET      = 8'hff;
  localparam logic [7:0]  INT_CTRL_RESET    = 8'h00;
  localparam logic [1:0]  QUARTER_DIV_LAST  = 2'h3;

  typedef enum logic [2:0] {
    ST_STARTUP  = 3'b000,
    ST_RUN      = 3'b001,
    ST_HALT     = 3'b010,
    ST_ISR_WAIT = 3'b011,
    ST_RESET    = 3'b100
  } state_type;
endpackage : halt_wake_pkg

// ===== verification/halt_wake_chk.sv
// Purpose: concurrent checks on the halt, wake and reset controller ports
// Assumes: one clock domain, srst_in synchronous active high
// Notes:   helper history masks edges where a synchronised reset is pending
`timescale 1ns/1ns
module halt_wake_chk
  import halt_wake_pkg::*;
(
  input wire logic             clock_in,
  input wire logic             srst_in,
  input wire logic             osc_tick_in,
  input wire logic             halt_instr_in,
  input wire logic             clear_wdt_instr_in,
  input wire logic             external_reset_pin_n_in,
  input wire logic             low_voltage_reset_enable_in,
  input wire logic             supply_low_in,
  input wire logic             system_clock_enable_out,
  input wire logic             quarter_rate_clock_out,
  input wire logic             timebase_rtc_run_out,
  input wire logic             hold_state_out,
  input wire logic             chip_reset_out,
  input wire logic             warm_reset_out,
  input wire logic             resume_next_out,
  input wire logic             isr_start_out,
  input wire logic             timeout_flag_out,
  input wire logic             power_down_flag_out,
  input wire logic [WDT_W-1:0] wdt_count_out,
  input wire logic [7:0]       timer_ctrl_out,
  input wire logic [5:0]       rtc_control_reg_out,
  input wire logic [7:0]       port_a_latch_out,
  input wire logic [7:0]       interrupt_control_low_out,
  input wire logic             ports_input_mode_out
);
  logic [2:0] pin_hist;
  logic       quiet;
  logic       run;
  // the pin passes two flops, so a low in the last cycles may still act
  always_ff @(posedge clock_in) pin_hist <= {pin_hist[1:0], external_reset_pin_n_in};
  assign quiet = &pin_hist && external_reset_pin_n_in && !(low_voltage_reset_enable_in && supply_low_in);
  assign run = system_clock_enable_out && !hold_state_out && !chip_reset_out;
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);

  halt_entry_a: assert property (halt_instr_in && run && quiet && wdt_count_out != 16'hffff |=> hold_state_out
    && !system_clock_enable_out && power_down_flag_out && !timeout_flag_out && wdt_count_out == '0) else $error("halt entry wrong");
  halt_clock_a: assert property (hold_state_out && $past(hold_state_out) |-> !system_clock_enable_out
    && timebase_rtc_run_out && $stable(quarter_rate_clock_out)) else $error("clocks wrong in halt");
  warm_keep_a: assert property (warm_reset_out |-> timeout_flag_out && power_down_flag_out
    && $stable(timer_ctrl_out) && $stable(port_a_latch_out) && $stable(rtc_control_reg_out)) else $error("warm reset wrong");
  pdf_source_a: assert property ($rose(power_down_flag_out) |-> $past(halt_instr_in))
    else $error("power down flag set without halt");
  pdf_clear_a: assert property (clear_wdt_instr_in && !halt_instr_in && run && quiet
    && wdt_count_out != 16'hffff |=> !power_down_flag_out) else $error("power down flag not cleared");
  wdt_run_a: assert property (wdt_count_out == 16'hffff && osc_tick_in && run && quiet && !clear_wdt_instr_in
    |=> chip_reset_out && timeout_flag_out && port_a_latch_out == PORT_A_RESET) else $error("run overflow wrong");
  resume_wake_a: assert property (resume_next_out |-> $past(hold_state_out) && !hold_state_out
    && system_clock_enable_out && !isr_start_out) else $error("resume pulse wrong");
  isr_delay_a: assert property ($fell(hold_state_out) && !resume_next_out && !warm_reset_out && !chip_reset_out
    |-> !isr_start_out ##1 !isr_start_out ##1 isr_start_out) else $error("service start delay wrong");
  reset_image_a: assert property (chip_reset_out |-> ports_input_mode_out && interrupt_control_low_out == INT_CTRL_RESET
    && timer_ctrl_out == TIMER_CTRL_RESET && rtc_control_reg_out == RTC_CTRL_RESET) else $error("reset image wrong");
  port_wake_c: cover property (resume_next_out);
  isr_wake_c: cover property (isr_start_out);
  warm_wake_c: cover property (warm_reset_out);
endmodule : halt_wake_chk

bind halt_wake_reset_control halt_wake_chk chk_i (.*);

// ===== verification/tb_halt_wake_reset_control.sv
// Purpose: self-checking bench for the halt, wake and reset controller
// Assumes: osc_tick_in pulses every cycle so the long counts stay short
// Notes:   flag model is kept in integers and compared after each event
`timescale 1ns/1ns
module tb_halt_wake_reset_control;
  import halt_wake_pkg::*;
  logic clock_in, srst_in, osc_tick_in, halt_instr_in, clear_wdt_instr_in, slow, reset_req;
  logic external_reset_pin_n_in, low_voltage_reset_enable_in, supply_low_in;
  logic lcd_run_in_halt_in, global_int_enable_in, stack_full_in;
  logic [7:0] port_a_pins_in, port_a_wake_enable_in, fall_mask;
  logic [INT_SRC_N-1:0] int_request_in, int_enable_in;
  logic system_clock_enable_out, quarter_rate_clock_out, timebase_rtc_run_out, lcd_run_out;
  logic hold_state_out, chip_reset_out, warm_reset_out, resume_next_out, isr_start_out;
  logic timeout_flag_out, power_down_flag_out, ports_input_mode_out;
  logic [WDT_W-1:0] wdt_count_out;
  logic [7:0] timer_ctrl_out, port_a_latch_out, interrupt_control_low_out;
  logic [5:0] rtc_control_reg_out;
  int err_count, samples_checked, cycles, n, j, k, m_to, m_pdf;

  halt_wake_reset_control DUT (.*);
  wake_source_model partner (.clock_in(clock_in), .slow_in(slow), .reset_req_in(reset_req), .fall_mask_in(fall_mask),
    .external_reset_pin_n_out(external_reset_pin_n_in), .port_a_pins_out(port_a_pins_in));

  // free running clock
  initial begin
    clock_in = 0;
    forever #4 clock_in = ~clock_in;
  end
  // hang guard sized for startup plus one watchdog period
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      results();
    end
  end

  task chk(string nm, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task flags;
    chk("timeout", m_to, timeout_flag_out);
    chk("power_down", m_pdf, power_down_flag_out);
  endtask : flags
  task images;
    chk("timer", TIMER_CTRL_RESET, timer_ctrl_out);
    chk("rtc", RTC_CTRL_RESET, rtc_control_reg_out);
    chk("port_a", PORT_A_RESET, port_a_latch_out);
    chk("int_ctrl", INT_CTRL_RESET, interrupt_control_low_out);
    chk("input_mode", 1, ports_input_mode_out);
  endtask : images
  function automatic logic sig(int w);
    case (w)
      0: return resume_next_out;
      1: return warm_reset_out;
      2: return !chip_reset_out;
      3: return chip_reset_out;
      default: return !hold_state_out;
    endcase
  endfunction : sig
  // bounded wait for one of the selected outputs
  task await(int w, int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock_in);
      #1;
      cnt++;
    end while (!sig(w) && cnt < lim);
  endtask : await
  // one-cycle halt (h=1) or watchdog clear (h=0) instruction
  task instr(bit h);
    @(posedge clock_in) begin
      halt_instr_in <= h;
      clear_wdt_instr_in <= !h;
    end
    @(posedge clock_in) begin
      halt_instr_in <= 0;
      clear_wdt_instr_in <= 0;
    end
    #1;
    m_pdf = h;
    if (h) m_to = 0;
    if (h) chk("halted", 3'b100, {hold_state_out, system_clock_enable_out, |wdt_count_out});
    flags();
  endtask : instr
  task results;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  initial begin
    {halt_instr_in, clear_wdt_instr_in, slow, reset_req, low_voltage_reset_enable_in, supply_low_in} = 0;
    {lcd_run_in_halt_in, global_int_enable_in, stack_full_in, fall_mask, port_a_wake_enable_in} = 0;
    {int_request_in, int_enable_in, m_to, m_pdf} = 0;
    srst_in = 1;
    osc_tick_in = 1;
    void'($urandom(32'h1247));
    repeat (6) @(posedge clock_in);
    #1;
    flags();
    images();
    @(posedge clock_in) srst_in <= 0;
    await(2, 9000, n);
    chk("startup", 8192, n);
    chk("sysclk", 1, system_clock_enable_out);
    for (k = 0; k < 8; k++) begin
      @(posedge clock_in) begin
        slow <= k[0];
        port_a_wake_enable_in <= 8'(1 << k);
        lcd_run_in_halt_in <= 1'($urandom);
      end
      instr(1);
      chk("lcd", {lcd_run_in_halt_in, 1'b1}, {lcd_run_out, timebase_rtc_run_out});
      @(posedge clock_in) fall_mask <= 8'(1 << ((k + 1 + $urandom % 7) % 8));
      await(0, 12, n);
      chk("no_wake", 1, hold_state_out);
      @(posedge clock_in) fall_mask <= 8'(1 << k);
      await(0, 12, n);
      chk("port_wake", 3'b101, {resume_next_out, hold_state_out, system_clock_enable_out});
      @(posedge clock_in) fall_mask <= 0;
    end
    instr(0);
    // interrupt cases: disabled, stack full, vectored, flag set before halt
    for (k = 0; k < 4; k++) begin
      j = $urandom % INT_SRC_N;
      @(posedge clock_in) begin
        port_a_wake_enable_in <= 8'(k == 3);
        int_enable_in <= (k == 0) ? '0 : INT_SRC_N'(1 << j);
        global_int_enable_in <= 1;
        stack_full_in <= (k == 1);
        int_request_in <= (k == 3) ? INT_SRC_N'(1 << j) : '0;
      end
      instr(1);
      @(posedge clock_in) int_request_in <= INT_SRC_N'(1 << j);
      await(k == 2 ? 4 : 0, 12, n);
      chk("int_wake", k == 3 ? 2'b01 : {k != 2, 1'b0}, {resume_next_out, hold_state_out});
      if (k == 2) begin
        repeat (2) begin
          @(posedge clock_in);
          #1;
        end
        chk("isr_start", 1, isr_start_out);
      end
      if (k == 3) begin
        @(posedge clock_in) fall_mask <= 8'h01;
        await(0, 12, n);
        @(posedge clock_in) fall_mask <= 0;
      end
    end
    @(posedge clock_in) supply_low_in <= 1;
    await(3, 8, n);
    chk("lvr_off", 0, chip_reset_out);
    // pin reset in halt, pin reset in run, enabled low voltage reset in run
    for (k = 0; k < 3; k++) begin
      if (k == 0) instr(1);
      @(posedge clock_in) begin
        reset_req <= (k < 2);
        low_voltage_reset_enable_in <= (k == 2);
      end
      await(3, 12, n);
      if (k == 0) m_pdf = 1;
      chk("chip_reset", 1, chip_reset_out);
      flags();
      images();
      @(posedge clock_in) begin
        reset_req <= 0;
        low_voltage_reset_enable_in <= 0;
      end
      await(2, 20, n);
    end
    @(posedge clock_in) supply_low_in <= 0;
    instr(1);
    await(1, 66000, n);
    m_to = 1;
    chk("wdt_period", 65536, n);
    chk("warm_wake", 2'b01, {hold_state_out, system_clock_enable_out});
    flags();
    images();
    results();
  end
endmodule : tb_halt_wake_reset_control

// ===== verification/wake_source_model.sv
// Purpose: far side stand-in driving the reset pin and the port a pins
// Assumes: requests arrive from the bench as levels changed on clock edges
// Notes:   slow mode answers three cycles later; released pins go to their pull-up
`timescale 1ns/1ns
module wake_source_model (
  input  wire logic       clock_in,
  input  wire logic       slow_in,
  input  wire logic       reset_req_in,
  input  wire logic [7:0] fall_mask_in,
  output logic            external_reset_pin_n_out,
  output logic [7:0]      port_a_pins_out
);
  logic [8:0] stage [4];
  logic [8:0] now_req;
  // delay line so the pins can lag a request the way a slow board does
  always_ff @(posedge clock_in) begin
    stage[0] <= {reset_req_in, fall_mask_in};
    for (int i = 1; i < 4; i++) stage[i] <= stage[i-1];
  end
  assign now_req = slow_in ? stage[3] : stage[0];
  // lines read high whenever nothing pulls them down
  assign external_reset_pin_n_out = !now_req[8];
  assign port_a_pins_out = ~now_req[7:0];
endmodule : wake_source_model
